// ---- hw/asp_core.sv ----
`timescale 1ns/1ps
module asp_core
   import asp_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // Primary link
   input wire logic primary_link_bit_clock_i,
   output logic primary_link_bit_clock_o,
   output logic primary_link_bit_clock_oe_n_o,
   output logic primary_link_frame_sync_o,
   output logic primary_link_data_out_o,
   output logic primary_link_reset_n_o,
   input wire logic primary_link_data_in_i,
   input wire logic second_codec_data_in_i,
   // Second link
   input wire logic second_link_bit_clock_i,
   output logic second_link_frame_sync_o,
   output logic second_link_data_out_o,
   output logic second_link_reset_n_o,
   // Video port
   input wire logic video_port_bit_clock_i,
   input wire logic video_port_lr_clock_i,
   input wire logic video_port_data_in_i,
   // Digital audio
   output logic digital_audio_out_o,
   input wire logic digital_audio_in_i,
   // Extended I/O, bits 3..6 double as the aux port
   input wire logic [7:0] extended_gp_io_i,
   output logic [7:0] extended_gp_io_o,
   output logic [7:0] extended_gp_io_oe_n_o,
   // DAC master clock
   output logic dac_master_clock_o
);
   import asp_pkg::*;

   // -------------------------------------------------------------------
   // Helpers
   // -------------------------------------------------------------------
   function automatic logic rise(input logic prev, input logic cur);
      rise = cur & ~prev;
   endfunction

   function automatic logic [31:0] wmask(input logic [31:0] old,
         input logic [31:0] nw, input logic [3:0] sel);
      for (int i = 0; i < 4; i++) begin
         old[i*8 +: 8] = sel[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
      end
      wmask = old;
   endfunction

   // -------------------------------------------------------------------
   // State
   // -------------------------------------------------------------------
   logic [31:0] ctrl_q, ctrl_d;
   logic [7:0] gdir_q, gdir_d, gpol_q, gpol_d, gedge_q, gedge_d;
   logic [7:0] gout_q, gout_d, gin_q, gin_d, gprev_q, gprev_d;
   logic [15:0] txl_q, txl_d, txr_q, txr_d, rxl_q, rxl_d, rxr_q, rxr_d;
   logic [15:0] spd_q, spd_d;
   logic [31:0] dat_q, dat_d;
   logic ack_q, ack_d;
   // Link clock samples and dividers.
   logic bc1_q, bc1_d, bc2_q, bc2_d, vbc_q, vbc_d;
   logic [7:0] slot1_q, slot1_d, slot2_q, slot2_d;
   logic [7:0] div_q, div_d;
   logic [1:0] dac_q, dac_d;
   logic [15:0] sh1_q, sh1_d, sh2_q, sh2_d, vsh_q, vsh_d;
   logic [15:0] ain_q, ain_d, aout_q, aout_d;
   logic [15:0] vword_q, vword_d;
   logic [4:0] abit_q, abit_d;
   logic afr_q, afr_d, abc_q, abc_d;
   logic [4:0] sbit_q, sbit_d;
   logic bmc_q, bmc_d, shalf_q, shalf_d;
   logic dprev_q, dprev_d;
   logic [7:0] dtrans_q, dtrans_d;
   logic prst1_q, prst1_d, prst2_q, prst2_d;

   logic dac, auxen, auxout, acc, wr;
   logic r1, r2, rv, aux_clk, aux_fr, aux_clk_r, pin_ac, pin_af;
   logic [7:0] gp_eff, gp_ev;
   logic [31:0] txl_w, txr_w, spd_w;

   assign dac = ctrl_q[ASP_C_DAC];
   assign auxen = ctrl_q[ASP_C_AUXEN];
   assign auxout = ctrl_q[ASP_C_AUXOUT] & ~dac;
   assign acc = cyc_i & stb_i & ~ack_q;
   assign wr = acc & we_i;
   assign r1 = rise(bc1_q, primary_link_bit_clock_i);
   assign r2 = rise(bc2_q, second_link_bit_clock_i);
   assign rv = rise(vbc_q, video_port_bit_clock_i);
   // Aux clocks share one counter so frame edges never slip off clock edges.
   assign aux_clk = div_q[1];
   assign aux_fr = div_q[7];
   assign pin_ac = auxout ? aux_clk : extended_gp_io_i[3];
   assign pin_af = auxout ? aux_fr : extended_gp_io_i[4];
   assign aux_clk_r = rise(abc_q, pin_ac);
   assign gp_eff = extended_gp_io_i ^ gpol_q;
   assign gp_ev = gedge_q & (gp_eff & ~gprev_q);
   assign txl_w = wmask({16'h0, txl_q}, dat_i, sel_i);
   assign txr_w = wmask({16'h0, txr_q}, dat_i, sel_i);
   assign spd_w = wmask({16'h0, spd_q}, dat_i, sel_i);

   // -------------------------------------------------------------------
   // Next state
   // -------------------------------------------------------------------
   always_comb begin
      ctrl_d = ctrl_q;
      gdir_d = gdir_q;
      gpol_d = gpol_q;
      gedge_d = gedge_q;
      gout_d = gout_q;
      txl_d = txl_q;
      txr_d = txr_q;
      spd_d = spd_q;
      dat_d = dat_q;
      ack_d = acc;
      gprev_d = gp_eff;
      // Edge bits stay set until software writes one; a new edge wins.
      gin_d = (gedge_q & gin_q) | (~gedge_q & gp_eff) | gp_ev;
      if (wr) begin
         case (adr_i)
            ASP_CTRL_OFS: ctrl_d = wmask(ctrl_q, dat_i, sel_i);
            ASP_GPDIR_OFS: if (sel_i[0]) gdir_d = dat_i[7:0];
            ASP_GPPOL_OFS: if (sel_i[0]) gpol_d = dat_i[7:0];
            ASP_GPEDGE_OFS: if (sel_i[0]) gedge_d = dat_i[7:0];
            ASP_GPOUT_OFS: if (sel_i[0]) gout_d = dat_i[7:0];
            ASP_GPIN_OFS: if (sel_i[0]) begin
               gin_d = (gin_q & ~(dat_i[7:0] & gedge_q)) | gp_ev
                     | (~gedge_q & gp_eff);
            end
            ASP_TXL_OFS: txl_d = txl_w[15:0];
            ASP_TXR_OFS: txr_d = txr_w[15:0];
            ASP_SPD_OFS: spd_d = spd_w[15:0];
            default: ;
         endcase
      end
      if (acc && !we_i) begin
         case (adr_i)
            ASP_CTRL_OFS: dat_d = ctrl_q;
            ASP_GPDIR_OFS: dat_d = {24'h0, gdir_q};
            ASP_GPPOL_OFS: dat_d = {24'h0, gpol_q};
            ASP_GPEDGE_OFS: dat_d = {24'h0, gedge_q};
            ASP_GPOUT_OFS: dat_d = {24'h0, gout_q};
            ASP_GPIN_OFS: dat_d = {24'h0, gin_q};
            ASP_TXL_OFS: dat_d = {16'h0, txl_q};
            ASP_TXR_OFS: dat_d = {16'h0, txr_q};
            ASP_RXL_OFS: dat_d = {16'h0, rxl_q};
            ASP_RXR_OFS: dat_d = {16'h0, rxr_q};
            ASP_STAT_OFS: dat_d = {dtrans_q, vword_q, 8'h0};
            ASP_SPD_OFS: dat_d = {16'h0, spd_q};
            default: dat_d = 32'h0000_0000;
         endcase
      end
   end

   always_comb begin
      bc1_d = primary_link_bit_clock_i;
      bc2_d = second_link_bit_clock_i;
      vbc_d = video_port_bit_clock_i;
      abc_d = pin_ac;
      slot1_d = slot1_q;
      slot2_d = slot2_q;
      sh1_d = sh1_q;
      sh2_d = sh2_q;
      vsh_d = vsh_q;
      vword_d = vword_q;
      div_d = div_q;
      dac_d = dac_q + 2'd1;
      ain_d = ain_q;
      aout_d = aout_q;
      abit_d = abit_q;
      afr_d = afr_q;
      rxl_d = rxl_q;
      rxr_d = rxr_q;
      // Frame counters run from the bit clock pins; the core drives the primary one itself in DAC mode.
      if (r1) begin
         slot1_d = slot1_q + 8'd1;
         sh1_d = {sh1_q[14:0], primary_link_data_in_i};
         div_d = div_q + 8'd1;
      end
      if (r2) begin
         slot2_d = slot2_q + 8'd1;
         sh2_d = {sh2_q[14:0], second_codec_data_in_i};
      end
      if (rv) begin
         vsh_d = {vsh_q[14:0], video_port_data_in_i};
         if (video_port_lr_clock_i) vword_d = vsh_q;
      end
      if (auxen && aux_clk_r) begin
         ain_d = {ain_q[14:0], extended_gp_io_i[5]};
         aout_d = {aout_q[14:0], 1'b0};
         abit_d = abit_q + 5'd1;
         afr_d = pin_af;
         // Words go MSB first after the frame edge and the rest of the slot
         // is padding, so a word is taken once its last bit is in.
         if (abit_q == 5'(ASP_WORD - 1)) begin
            if (afr_q) rxr_d = ain_d;
            else rxl_d = ain_d;
         end
         if (pin_af != afr_q) begin
            aout_d = pin_af ? txr_q : txl_q;
            abit_d = 5'd0;
         end
      end
   end

   // Bi-phase mark: toggle at every cell, toggle mid-cell for a one.
   always_comb begin
      sbit_d = sbit_q;
      bmc_d = bmc_q;
      shalf_d = ~shalf_q;
      dprev_d = digital_audio_in_i;
      dtrans_d = dtrans_q + {7'h0, digital_audio_in_i ^ dprev_q};
      if (ctrl_q[ASP_C_SPDEN]) begin
         if (!shalf_q) bmc_d = ~bmc_q;
         else if (spd_q[sbit_q[3:0]]) bmc_d = ~bmc_q;
         if (shalf_q) sbit_d = sbit_q + 5'd1;
      end
   end

   always_comb begin
      prst1_d = prst1_q;
      prst2_d = prst2_q;
      if (wr && adr_i == ASP_CTRL_OFS && sel_i[0]) begin
         prst1_d = dat_i[ASP_C_RST1];
         prst2_d = dat_i[ASP_C_RST2];
      end
   end

   // -------------------------------------------------------------------
   // Registers
   // -------------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_q <= ASP_CTRL_RST;
         {gdir_q, gpol_q, gedge_q, gout_q, gin_q, gprev_q} <= 48'h0;
         {txl_q, txr_q, rxl_q, rxr_q, spd_q} <= 80'h0;
         dat_q <= 32'h0;
         ack_q <= 1'b0;
         {bc1_q, bc2_q, vbc_q, abc_q, afr_q} <= 5'h0;
         {slot1_q, slot2_q, div_q} <= 24'h0;
         dac_q <= 2'h0;
         {sh1_q, sh2_q, vsh_q, ain_q, aout_q, vword_q} <= 96'h0;
         abit_q <= 5'h0;
         {sbit_q, bmc_q, shalf_q, dprev_q} <= 8'h0;
         dtrans_q <= 8'h0;
         prst1_q <= 1'b0;
         prst2_q <= 1'b0;
      end else begin
         ctrl_q <= ctrl_d;
         gdir_q <= gdir_d;
         gpol_q <= gpol_d;
         gedge_q <= gedge_d;
         gout_q <= gout_d;
         gin_q <= gin_d;
         gprev_q <= gprev_d;
         txl_q <= txl_d;
         txr_q <= txr_d;
         rxl_q <= rxl_d;
         rxr_q <= rxr_d;
         spd_q <= spd_d;
         dat_q <= dat_d;
         ack_q <= ack_d;
         bc1_q <= bc1_d;
         bc2_q <= bc2_d;
         vbc_q <= vbc_d;
         abc_q <= abc_d;
         afr_q <= afr_d;
         slot1_q <= slot1_d;
         slot2_q <= slot2_d;
         div_q <= div_d;
         dac_q <= dac_d;
         sh1_q <= sh1_d;
         sh2_q <= sh2_d;
         vsh_q <= vsh_d;
         ain_q <= ain_d;
         aout_q <= aout_d;
         vword_q <= vword_d;
         abit_q <= abit_d;
         sbit_q <= sbit_d;
         bmc_q <= bmc_d;
         shalf_q <= shalf_d;
         dprev_q <= dprev_d;
         dtrans_q <= dtrans_d;
         prst1_q <= prst1_d;
         prst2_q <= prst2_d;
      end
   end

   // -------------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------------
   assign dat_o = dat_q;
   assign ack_o = ack_q;
   // DAC mode runs off the system clock, so no codec clock is needed then.
   assign primary_link_bit_clock_o = dac_q[1];
   assign primary_link_bit_clock_oe_n_o = ~dac;
   // A frame of 128 bit clocks puts the master clock at 256 times the rate.
   assign primary_link_frame_sync_o = dac ? slot1_q[6]
         : (slot1_q < 8'(ASP_SYNC_BITS));
   assign primary_link_data_out_o = sh1_q[15];
   assign primary_link_reset_n_o = prst1_q;
   assign second_link_frame_sync_o = slot2_q < 8'(ASP_SYNC_BITS);
   assign second_link_data_out_o = sh2_q[15];
   assign second_link_reset_n_o = prst2_q;
   assign digital_audio_out_o = bmc_q;
   assign dac_master_clock_o = dac & ctrl_q[ASP_C_MCLKEN]
         & dac_q[0];

   always_comb begin
      extended_gp_io_o = gout_q ^ gpol_q;
      extended_gp_io_oe_n_o = ~gdir_q;
      if (auxen) begin
         extended_gp_io_o[3] = aux_clk;
         extended_gp_io_o[4] = aux_fr;
         extended_gp_io_o[6] = aout_q[15];
         extended_gp_io_oe_n_o[3] = ~auxout;
         extended_gp_io_oe_n_o[4] = ~auxout;
         extended_gp_io_oe_n_o[5] = 1'b1;
         extended_gp_io_oe_n_o[6] = 1'b0;
      end
   end
endmodule

// ---- hw/asp_pkg.sv ----
package asp_pkg;
   // -------------------------------------------------------------------
   // Register map
   // -------------------------------------------------------------------
   localparam logic [7:0] ASP_CTRL_OFS = 8'h00;
   localparam logic [7:0] ASP_GPDIR_OFS = 8'h04;
   localparam logic [7:0] ASP_GPPOL_OFS = 8'h08;
   localparam logic [7:0] ASP_GPEDGE_OFS = 8'h0c;
   localparam logic [7:0] ASP_GPOUT_OFS = 8'h10;
   localparam logic [7:0] ASP_GPIN_OFS = 8'h14;
   localparam logic [7:0] ASP_TXL_OFS = 8'h18;
   localparam logic [7:0] ASP_TXR_OFS = 8'h1c;
   localparam logic [7:0] ASP_RXL_OFS = 8'h20;
   localparam logic [7:0] ASP_RXR_OFS = 8'h24;
   localparam logic [7:0] ASP_STAT_OFS = 8'h28;
   localparam logic [7:0] ASP_SPD_OFS = 8'h2c;
   // Control fields.
   localparam int ASP_C_DAC = 0;
   localparam int ASP_C_RST1 = 1;
   localparam int ASP_C_RST2 = 2;
   localparam int ASP_C_AUXEN = 3;
   localparam int ASP_C_AUXOUT = 4;
   localparam int ASP_C_MCLKEN = 5;
   localparam int ASP_C_SPDEN = 6;
   localparam logic [31:0] ASP_CTRL_RST = 32'h0000_0000;
   // -------------------------------------------------------------------
   // Timing
   // -------------------------------------------------------------------
   localparam int ASP_SLOT_BITS = 256;
   localparam int ASP_SYNC_BITS = 16;
   localparam int ASP_AUX_CDIV = 4;
   localparam int ASP_AUX_FDIV = 64;
   localparam int ASP_MCLK_MUL = 256;
   localparam int ASP_DAC_HALF = 2;
   localparam int ASP_WORD = 16;
   localparam int ASP_GP_W = 8;
endpackage

// ---- tb/asp_core_assertions.sv ----
`timescale 1ns/1ps
module asp_core_assertions
   import asp_pkg::*;
(
   // Clock, reset and bus
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic [31:0] dat_o,
   input wire logic ack_o,
   // Pins
   input wire logic primary_link_bit_clock_oe_n_o,
   input wire logic primary_link_reset_n_o,
   input wire logic second_link_reset_n_o,
   input wire logic [7:0] extended_gp_io_oe_n_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   property p_ack_once; ack_o |=> !ack_o; endproperty
   a_ack_once: assert property (p_ack_once) else $error("ack held");
   property p_ack_answer; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
   a_ack_answer: assert property (p_ack_answer) else $error("no ack");
   property p_ack_cause; ack_o |-> $past(cyc_i && stb_i); endproperty
   a_ack_cause: assert property (p_ack_cause) else $error("stray ack");
   property p_rst_outs;
      disable iff (1'b0)
      rst_i |=> !primary_link_reset_n_o && !second_link_reset_n_o;
   endproperty
   a_rst_outs: assert property (p_rst_outs) else $error("reset high");
   property p_bus_idle;
      disable iff (1'b0) rst_i |=> !ack_o && dat_o == 32'h0;
   endproperty
   a_bus_idle: assert property (p_bus_idle) else $error("bus not idle");
   property p_oe_idle;
      disable iff (1'b0)
      rst_i |=> &extended_gp_io_oe_n_o && primary_link_bit_clock_oe_n_o;
   endproperty
   a_oe_idle: assert property (p_oe_idle) else $error("pin driven");
   property p_rst1_sw;
      $rose(primary_link_reset_n_o) |-> ack_o || $past(ack_o) ||
         $past(ack_o, 2);
   endproperty
   a_rst1_sw: assert property (p_rst1_sw) else $error("reset rose");
   property p_rst2_sw;
      $rose(second_link_reset_n_o) |-> ack_o || $past(ack_o) ||
         $past(ack_o, 2);
   endproperty
   a_rst2_sw: assert property (p_rst2_sw) else $error("reset2 rose");
   property p_gp_dir;
      $changed(extended_gp_io_oe_n_o) |-> ack_o || $past(ack_o) ||
         $past(ack_o, 2);
   endproperty
   a_gp_dir: assert property (p_gp_dir) else $error("dir moved");
   property p_bclk_oe;
      $changed(primary_link_bit_clock_oe_n_o) |-> ack_o || $past(ack_o) ||
         $past(ack_o, 2);
   endproperty
   a_bclk_oe: assert property (p_bclk_oe) else $error("clk dir");
endmodule
bind asp_core asp_core_assertions asp_core_assertions_i (.clk_i, .rst_i,
   .cyc_i, .stb_i, .dat_o, .ack_o, .primary_link_bit_clock_oe_n_o,
   .primary_link_reset_n_o, .second_link_reset_n_o, .extended_gp_io_oe_n_o);

// ---- tb/asp_codec_model.sv ----
`timescale 1ns/1ps
module asp_codec_model (
   // Link side
   input wire logic bit_clock_oe_n_i,
   output logic bit_clock_o,
   output logic bit_clock2_o,
   output logic data_in_o,
   output logic data_in2_o,
   // Video and digital audio sources
   output logic video_clk_o,
   output logic video_lr_o,
   output logic video_dat_o,
   output logic spdif_o
);
   logic [3:0] vcnt;
   initial begin
      {bit_clock_o, bit_clock2_o, data_in_o, data_in2_o} = 4'h0;
      {video_clk_o, video_lr_o, video_dat_o, spdif_o, vcnt} = 8'h00;
   end
   // Codec clocks run free, as link codecs do.
   always #40 bit_clock_o = ~bit_clock_o;
   always #42 bit_clock2_o = ~bit_clock2_o;
   // Data moves on the codec edge; data_in_o is pulled low once the core drives the bit clock.
   always @(posedge bit_clock_o) begin
      data_in_o <= bit_clock_oe_n_i ? 1'($urandom) : 1'b0;
      data_in2_o <= 1'($urandom);
   end
   // The video source drives clock, channel clock and data.
   always #96 video_clk_o = ~video_clk_o;
   always @(negedge video_clk_o) begin
      vcnt <= vcnt + 4'h1;
      video_lr_o <= (vcnt == 4'hf) ? ~video_lr_o : video_lr_o;
      video_dat_o <= 1'($urandom);
   end
   // Bi-phase mark: a change per cell, one more mid-cell for a one.
   always begin
      #60 spdif_o = ~spdif_o;
      #60 if ($urandom % 2 == 1) spdif_o = ~spdif_o;
   end
endmodule

// ---- tb/asp_core_tb_top.sv ----
`timescale 1ns/1ps
module asp_core_tb_top;
   import asp_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic loop = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0;
   logic [7:0] gp_drv = 8'h00;
   logic [31:0] exp_q[$];
   logic [15:0] tl, tr;
   logic [7:0] p8, v8;
   logic last;
   int n;
   int failures = 0;
   int checks = 0;
   int cycles = 0;
   wire [31:0] dat;
   wire ack, bclk_o, bclk_oe_n, fsync, rst1_n, rst2_n, spd_o, mclk, fs2;
   wire cclk, cclk2, sdin, sdin2, zclk, zlr, zdat, spd_in;
   wire [7:0] gp_o, gp_oe_n;
   wire link_pin = bclk_oe_n ? cclk : bclk_o;
   wire [7:0] gp_in = loop ? {gp_drv[7:6], gp_o[6], gp_drv[4:0]} : gp_drv;
   wire [8:0] mon = {fs2, cclk2, mclk, fsync, bclk_o, gp_o[4], gp_o[3],
      link_pin, 1'b0};
   always #5 clk_i = ~clk_i;
   asp_core asp_core_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
      .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'hf), .dat_i(wdat),
      .dat_o(dat), .ack_o(ack), .primary_link_bit_clock_i(link_pin),
      .primary_link_bit_clock_o(bclk_o),
      .primary_link_bit_clock_oe_n_o(bclk_oe_n),
      .primary_link_frame_sync_o(fsync), .primary_link_data_out_o(),
      .primary_link_reset_n_o(rst1_n), .primary_link_data_in_i(sdin),
      .second_codec_data_in_i(sdin2), .second_link_bit_clock_i(cclk2),
      .second_link_frame_sync_o(fs2), .second_link_data_out_o(),
      .second_link_reset_n_o(rst2_n), .video_port_bit_clock_i(zclk),
      .video_port_lr_clock_i(zlr), .video_port_data_in_i(zdat),
      .digital_audio_out_o(spd_o), .digital_audio_in_i(spd_in),
      .extended_gp_io_i(gp_in), .extended_gp_io_o(gp_o),
      .extended_gp_io_oe_n_o(gp_oe_n), .dac_master_clock_o(mclk));
   asp_codec_model asp_codec_model_i (.bit_clock_oe_n_i(bclk_oe_n),
      .bit_clock_o(cclk), .bit_clock2_o(cclk2), .data_in_o(sdin),
      .data_in2_o(sdin2), .video_clk_o(zclk), .video_lr_o(zlr),
      .video_dat_o(zdat), .spdif_o(spd_in));
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      checks++;
      if (s !== e) begin
         failures++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic end_of_test();
      $display("failures=%0d checks=%0d", failures, checks);
      if (failures == 0 && checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // Bus cycle: hold the request until ack is seen, then one idle cycle.
   task automatic wb(input logic w, input logic [7:0] a,
         input logic [31:0] d);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do @(posedge clk_i); while (ack !== 1'b1);
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      wb(1'b0, a, 32'h0);
   endtask
   // Counts rises of mon[a] (or cycles, for a of 0) in one mon[b] period.
   task automatic per(input int a, input int b, output int cnt);
      logic pa, pb;
      for (int i = 0; i < 2; i++) begin
         cnt = 0;
         do begin
            pa = mon[a];
            pb = mon[b];
            @(posedge clk_i);
            if (a == 0 || (mon[a] && !pa)) cnt++;
         end while (!(mon[b] && !pb));
      end
   endtask
   always @(posedge clk_i) begin
      if (ack === 1'b1 && we === 1'b0) begin
         if (exp_q.size() == 0) chk(dat, 32'hdead_beef);
         else chk(dat, exp_q.pop_front());
      end
   end
   // The whole run takes under 20000 cycles; three times that means a hang.
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 60000) begin
         failures++;
         end_of_test();
      end
   end
   initial begin
      void'($urandom(30));
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      chk(rst1_n, 1'b0);
      chk(rst2_n, 1'b0);
      chk(gp_oe_n, 8'hff);
      chk(bclk_oe_n, 1'b1);
      rd(ASP_CTRL_OFS, ASP_CTRL_RST);
      rd(ASP_GPDIR_OFS, 32'h0);
      wb(1'b1, 8'h3c, 32'hffff_ffff);
      rd(8'h3c, 32'h0);
      wb(1'b1, ASP_CTRL_OFS, 32'h1 << ASP_C_RST1);
      chk(rst1_n, 1'b1);
      chk(rst2_n, 1'b0);
      wb(1'b1, ASP_CTRL_OFS, (32'h1 << ASP_C_RST1) | (32'h1 << ASP_C_RST2));
      chk(rst2_n, 1'b1);
      per(1, 5, n);
      chk(32'(n), 32'(ASP_SLOT_BITS));
      per(7, 8, n);
      chk(32'(n), 32'(ASP_SLOT_BITS));
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      chk({rst1_n, rst2_n}, 2'b00);
      rd(ASP_CTRL_OFS, ASP_CTRL_RST);
      p8 = 8'($urandom);
      v8 = 8'($urandom);
      wb(1'b1, ASP_GPDIR_OFS, 32'hff);
      wb(1'b1, ASP_GPPOL_OFS, {24'h0, p8});
      wb(1'b1, ASP_GPOUT_OFS, {24'h0, v8});
      chk(gp_o, v8 ^ p8);
      chk(gp_oe_n, 8'h00);
      wb(1'b1, ASP_GPDIR_OFS, 32'h0);
      gp_drv <= v8;
      repeat (4) @(posedge clk_i);
      rd(ASP_GPIN_OFS, {24'h0, v8 ^ p8});
      wb(1'b1, ASP_GPPOL_OFS, 32'h0);
      gp_drv <= 8'h00;
      wb(1'b1, ASP_GPEDGE_OFS, 32'hff);
      wb(1'b1, ASP_GPIN_OFS, 32'hff);
      gp_drv <= v8;
      repeat (4) @(posedge clk_i);
      gp_drv <= 8'h00;
      repeat (4) @(posedge clk_i);
      rd(ASP_GPIN_OFS, {24'h0, v8});
      wb(1'b1, ASP_GPIN_OFS, 32'hff);
      rd(ASP_GPIN_OFS, 32'h0);
      tl = 16'($urandom);
      tr = 16'($urandom);
      wb(1'b1, ASP_TXL_OFS, {16'h0, tl});
      wb(1'b1, ASP_TXR_OFS, {16'h0, tr});
      loop <= 1'b1;
      wb(1'b1, ASP_CTRL_OFS, 32'h1e);
      chk(gp_oe_n[6:3], 4'b0100);
      per(1, 2, n);
      chk(32'(n), 32'(ASP_AUX_CDIV));
      per(2, 3, n);
      chk(32'(n), 32'(ASP_AUX_FDIV));
      per(2, 3, n);
      rd(ASP_RXL_OFS, {16'h0, tl});
      rd(ASP_RXR_OFS, {16'h0, tr});
      tl = 16'($urandom);
      wb(1'b1, ASP_SPD_OFS, {16'h0, tl});
      wb(1'b1, ASP_CTRL_OFS, (32'h1 << ASP_C_SPDEN) | 32'h6);
      repeat (64) @(posedge clk_i);
      n = 0;
      last = spd_o;
      repeat (4 * ASP_WORD / 2) begin
         @(posedge clk_i);
         if (spd_o !== last) n++;
         last = spd_o;
      end
      chk(32'(n), 32'(ASP_WORD + $countones(tl)));
      loop <= 1'b0;
      wb(1'b1, ASP_CTRL_OFS,
         (32'h1 << ASP_C_DAC) | (32'h1 << ASP_C_MCLKEN) | 32'h6);
      chk(bclk_oe_n, 1'b0);
      per(0, 4, n);
      chk(32'(n), 32'(2 * ASP_DAC_HALF));
      per(4, 5, n);
      chk(32'(n), 32'h80);
      per(6, 5, n);
      chk(32'(n), 32'(ASP_MCLK_MUL));
      end_of_test();
   end
endmodule
